// file: verilog/sie_stack_int.sv
// Stack pointer, push/pop sequencer and interrupt enable logic
//
// How it works
// - Stack pointer decrements per pushed byte, increments per popped byte.
// - Stack pointer lives at FEH/FFH, readable and writable as registers.
// - Port mode register F8H bit 2 selects stack location.
// - Internal stack uses low byte only; high byte stays a plain register.
// - Call pushes the return address then loads the program counter.
// - Return pops two bytes into the program counter.
// - Interrupt entry pushes program counter, then status flags.
// - Interrupt return pops flags into FCH, then two program counter bytes.
// - Push decrements pointer first, then writes at the new address.
// - Pop reads at the pointer first, then increments it.
// - Push/pop operand may be direct or indirect register; decoder supplies it.
// - Six sources; mask at FBH, priority at F9H.
// - Request enabled only with its mask bit and global bit 7 both set.
// - Enabled requests vector automatically; disabled ones stay visible for polling.
// - Reset holds request register FAH at zero until first enable op.
// - Only the enable op releases the request register, not a mask write.
// - After release, writing mask bit 7 also enables globally.
// - Disable op clears mask bit 7.
// - Simultaneous enabled requests resolved by the priority register.
// - Entry pushes PC low, PC high, flags; clears request and global enable.
// - Entry jumps through the word at program addresses 2x, 2x+1.
// - Interrupt return also sets the global enable.
`timescale 1ns/1ps
module sie_stack_int
   import sie_pkg::*;
(
   input wire logic CLK,
   input wire logic RESETN,
   input wire sie_cmd_t CMD,
   input wire logic [15:0] INT_PC,
   input wire logic INT_SAMPLE,
   input wire logic [5:0] INT_SOURCE,
   input wire logic REG_WE,
   input wire logic REG_RD,
   input wire logic [7:0] REG_ADDR,
   input wire logic [7:0] REG_WDATA,
   output logic [7:0] REG_RDATA,
   output logic REG_HIT,
   output sie_mem_t MEM,
   input wire logic [7:0] MEM_RDATA,
   output logic BUSY,
   output logic DONE,
   output logic [7:0] POP_DATA,
   output logic PC_LOAD,
   output logic [15:0] PC_VALUE,
   output logic INT_ACK,
   output logic [2:0] INT_ID
);

   sie_regs_t q;
   sie_regs_t d;

   // Pointer step; internal stack moves only the low byte
   function automatic logic [15:0] sp_next(input logic [15:0] sp, input logic ext, input logic up);
      logic [15:0] delta;
      delta = up ? 16'h0001 : 16'hFFFF;
      if (ext) begin
         return sp + delta;
      end
      return {sp[15:8], sp[7:0] + delta[7:0]};
   endfunction

   // Stack address seen by memory
   function automatic logic [15:0] stack_addr(input logic [15:0] sp, input logic ext);
      return ext ? sp : {8'h00, sp[7:0]};
   endfunction

   // Bus action per sequence step
   function automatic sie_act_t step_act(input sie_op_t kind, input logic [2:0] step);
      case (kind)
         OP_PUSH, OP_CALL: begin
            return ACT_WRITE;
         end
         OP_INT: begin
            return (step > 3'h2) ? ACT_READ_PROG : ACT_WRITE;
         end
         default: begin
            return ACT_READ_STACK;
         end
      endcase
   endfunction

   // Last step index per sequence
   function automatic logic [2:0] step_last(input sie_op_t kind);
      case (kind)
         OP_CALL, OP_RET: begin
            return LAST_TWO;
         end
         OP_INTERRUPT_RETURN: begin
            return LAST_THREE;
         end
         OP_INT: begin
            return LAST_INT;
         end
         default: begin
            return LAST_ONE;
         end
      endcase
   endfunction

   // Captured byte is the program counter high byte
   function automatic logic cap_high(input sie_op_t kind, input logic [2:0] step);
      return (kind == OP_RET && step == 3'h0) || (kind == OP_INTERRUPT_RETURN && step == 3'h1) ||
         (kind == OP_INT && step == 3'h3);
   endfunction

   // Rotating priority: scan starts at the source named by the priority register
   function automatic logic [2:0] prio_pick(input logic [5:0] pend, input logic [7:0] interrupt_priority);
      logic [2:0] start;
      logic [2:0] idx;
      logic [2:0] pick;
      logic found;
      logic [3:0] sum;
      start = (interrupt_priority[2:0] > 3'h5) ? 3'h0 : interrupt_priority[2:0];
      pick = 3'h0;
      found = 1'b0;
      for (int i = 0; i < NUM_SOURCES; i++) begin
         // Four-bit sum so the wrap past source 5 is not lost
         sum = {1'b0, start} + 4'(i);
         idx = (sum > 4'h5) ? 3'(sum - 4'h6) : sum[2:0];
         if (!found && pend[idx]) begin
            pick = idx;
            found = 1'b1;
         end
      end
      return pick;
   endfunction

   // Decode helpers shared by the next-state logic
   logic ext;
   logic [5:0] enabled;
   sie_act_t act;
   logic [15:0] sp_dn;
   logic [7:0] wval;
   logic [7:0] irq_clr;
   logic [7:0] irq_base;

   // Next-state logic of the whole unit
   always_comb begin
      d = q;
      d.mem = '0;
      d.done = 1'b0;
      d.pc_load = 1'b0;
      d.int_ack = 1'b0;
      d.reg_hit = 1'b0;
      irq_clr = 8'h00;
      irq_base = q.irq;
      // Stack location, enabled requests and byte to write
      ext = ~q.port_mode[STACK_SEL_BIT];
      enabled = q.irq[5:0] & q.interrupt_mask[5:0] & {6{q.interrupt_mask[GLOBAL_EN_BIT]}};
      act = step_act(q.kind, q.step);
      sp_dn = sp_next(q.sp, ext, 1'b0);
      wval = (q.kind == OP_INT && q.step == 3'h2) ? q.flags : (q.step[0] ? q.tmp[15:8] : q.tmp[7:0]);

      // Register reads
      if (REG_RD) begin
         d.reg_hit = 1'b1;
         case (REG_ADDR)
            ADDR_PORT_MODE: d.rdata = q.port_mode;
            ADDR_INT_PRIORITY: d.rdata = q.interrupt_priority;
            ADDR_INT_REQUEST: d.rdata = q.irq & INT_REQ_USED;
            ADDR_INT_MASK: d.rdata = q.interrupt_mask;
            ADDR_STATUS_FLAGS: d.rdata = q.flags;
            ADDR_SP_HIGH: d.rdata = q.sp[15:8];
            ADDR_SP_LOW: d.rdata = q.sp[7:0];
            default: begin
               d.rdata = 8'h00;
               d.reg_hit = 1'b0;
            end
         endcase
      end

      // Register writes
      if (REG_WE) begin
         case (REG_ADDR)
            ADDR_PORT_MODE: d.port_mode = REG_WDATA;
            ADDR_INT_PRIORITY: d.interrupt_priority = REG_WDATA;
            ADDR_INT_REQUEST: irq_base = REG_WDATA & INT_REQ_USED;
            ADDR_INT_MASK: d.interrupt_mask = REG_WDATA;
            ADDR_STATUS_FLAGS: d.flags = REG_WDATA;
            ADDR_SP_HIGH: d.sp[15:8] = REG_WDATA;
            ADDR_SP_LOW: d.sp[7:0] = REG_WDATA;
            default: begin
            end
         endcase
      end

      // Sequencer
      case (q.st)
         // Idle: take a command, else an enabled request
         ST_IDLE: begin
            if (CMD.valid) begin
               d.kind = CMD.code;
               d.step = 3'h0;
               // Enable and disable ops finish in one cycle
               if (CMD.code == OP_EI) begin
                  d.interrupt_mask[GLOBAL_EN_BIT] = 1'b1;
                  d.released = 1'b1;
                  d.done = 1'b1;
               end else if (CMD.code == OP_DI) begin
                  d.interrupt_mask[GLOBAL_EN_BIT] = 1'b0;
                  d.done = 1'b1;
               end else begin
                  // Operand byte or return address into the work word
                  d.tmp = (CMD.code == OP_PUSH) ? {8'h00, CMD.data} : CMD.ret_pc;
                  if (CMD.code == OP_CALL) begin
                     d.pc = CMD.target;
                  end
                  d.busy = 1'b1;
                  d.st = ST_ISSUE;
               end
            end else if (INT_SAMPLE && |enabled) begin
               // Entry only at an instruction boundary
               d.kind = OP_INT;
               d.step = 3'h0;
               d.vec = prio_pick(enabled, q.interrupt_priority);
               d.tmp = INT_PC;
               // Serviced bit and global enable drop together
               irq_clr[d.vec] = 1'b1;
               d.interrupt_mask[GLOBAL_EN_BIT] = 1'b0;
               d.busy = 1'b1;
               d.st = ST_ISSUE;
            end
         end
         // Issue one memory request
         ST_ISSUE: begin
            d.st = ST_WAIT;
            d.mem.ext = ext;
            // Pointer moves before a write, after a read
            if (act == ACT_WRITE) begin
               d.sp = sp_dn;
               d.mem.wr = 1'b1;
               d.mem.addr = stack_addr(sp_dn, ext);
               d.mem.wdata = wval;
            end else if (act == ACT_READ_STACK) begin
               d.mem.rd = 1'b1;
               d.mem.addr = stack_addr(q.sp, ext);
            end else begin
               d.mem.rd = 1'b1;
               d.mem.ext = 1'b0;
               d.mem.prog = 1'b1;
               d.mem.addr = {12'h000, q.vec, q.step == STEP_VEC_LO};
            end
         end
         // Request on the bus this cycle
         ST_WAIT: begin
            // Reads capture next cycle; writes step on at once
            if (act != ACT_WRITE) begin
               d.st = ST_CAPT;
            end else if (q.step == step_last(q.kind)) begin
               d.st = ST_FINISH;
            end else begin
               d.step = q.step + 3'h1;
               d.st = ST_ISSUE;
            end
         end
         // Read data stands this cycle
         ST_CAPT: begin
            if (act == ACT_READ_STACK) begin
               d.sp = sp_next(q.sp, ext, 1'b1);
            end
            // Route the returned byte
            if (q.kind == OP_POP) begin
               d.pop_data = MEM_RDATA;
            end else if (q.kind == OP_INTERRUPT_RETURN && q.step == 3'h0) begin
               d.flags = MEM_RDATA;
            end else if (cap_high(q.kind, q.step)) begin
               d.tmp[15:8] = MEM_RDATA;
            end else begin
               d.tmp[7:0] = MEM_RDATA;
            end
            // Next byte or wind up
            if (q.step == step_last(q.kind)) begin
               d.st = ST_FINISH;
            end else begin
               d.step = q.step + 3'h1;
               d.st = ST_ISSUE;
            end
         end
         // Last cycle of a sequence
         ST_FINISH: begin
            d.st = ST_IDLE;
            d.busy = 1'b0;
            d.done = 1'b1;
            // Program counter handed over with done
            if (q.kind == OP_CALL) begin
               d.pc_load = 1'b1;
            end else if (q.kind == OP_RET || q.kind == OP_INTERRUPT_RETURN || q.kind == OP_INT) begin
               d.pc = q.tmp;
               d.pc_load = 1'b1;
            end
            // Interrupt return enables globally again
            if (q.kind == OP_INTERRUPT_RETURN) begin
               d.interrupt_mask[GLOBAL_EN_BIT] = 1'b1;
            end
            // Acknowledge carries the serviced source
            if (q.kind == OP_INT) begin
               d.int_ack = 1'b1;
               d.int_id = q.vec;
            end
         end
         default: begin
            d.st = ST_IDLE;
            d.busy = 1'b0;
         end
      endcase

      // Request register: new arrivals win over clears, held at zero until released
      if (d.released) begin
         d.irq = (irq_base & ~irq_clr) | {2'b00, INT_SOURCE};
      end else begin
         d.irq = 8'h00;
      end
   end

   // State register
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         q <= '{st: ST_IDLE, kind: OP_PUSH, step: 3'h0, released: 1'b0, port_mode: RST_BYTE,
            interrupt_priority: RST_BYTE, irq: RST_BYTE, interrupt_mask: RST_BYTE, flags: RST_BYTE, sp: RST_WORD,
            tmp: RST_WORD, vec: 3'h0, mem: '0, rdata: RST_BYTE, reg_hit: 1'b0, done: 1'b0,
            pop_data: RST_BYTE, pc_load: 1'b0, pc: RST_WORD, int_ack: 1'b0, int_id: 3'h0,
            busy: 1'b0};
      end else begin
         q <= d;
      end
   end

   // Outputs straight from the state register
   assign REG_RDATA = q.rdata;
   assign REG_HIT = q.reg_hit;
   assign MEM = q.mem;
   assign BUSY = q.busy;
   assign DONE = q.done;
   assign POP_DATA = q.pop_data;
   assign PC_LOAD = q.pc_load;
   assign PC_VALUE = q.pc;
   assign INT_ACK = q.int_ack;
   assign INT_ID = q.int_id;

endmodule // sie_stack_int

// file: verilog/sie_pkg.sv
// Package: register map, constants and carrier types of the stack and interrupt enable unit
package sie_pkg;

   // Register offsets in the register space
   localparam logic [7:0] ADDR_PORT_MODE = 8'hF8;
   localparam logic [7:0] ADDR_INT_PRIORITY = 8'hF9;
   localparam logic [7:0] ADDR_INT_REQUEST = 8'hFA;
   localparam logic [7:0] ADDR_INT_MASK = 8'hFB;
   localparam logic [7:0] ADDR_STATUS_FLAGS = 8'hFC;
   localparam logic [7:0] ADDR_SP_HIGH = 8'hFE;
   localparam logic [7:0] ADDR_SP_LOW = 8'hFF;

   // Field positions
   localparam int STACK_SEL_BIT = 2;
   localparam int GLOBAL_EN_BIT = 7;
   localparam int NUM_SOURCES = 6;

   // Values after reset; request bits in use
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [15:0] RST_WORD = 16'h0000;
   localparam logic [7:0] INT_REQ_USED = 8'h3F;

   // Last step index of each sequence; step of the vector low byte read
   localparam logic [2:0] LAST_ONE = 3'h0;
   localparam logic [2:0] LAST_TWO = 3'h1;
   localparam logic [2:0] LAST_THREE = 3'h2;
   localparam logic [2:0] LAST_INT = 3'h4;
   localparam logic [2:0] STEP_VEC_LO = 3'h4;

   // Operations; OP_INT is raised internally only
   typedef enum logic [2:0] {
      OP_PUSH = 3'h0, OP_POP = 3'h1, OP_CALL = 3'h2, OP_RET = 3'h3,
      OP_INTERRUPT_RETURN = 3'h4, OP_EI = 3'h5, OP_DI = 3'h6, OP_INT = 3'h7
   } sie_op_t;

   // Bus action of one sequence step
   typedef enum logic [1:0] {
      ACT_WRITE = 2'h1, ACT_READ_STACK = 2'h2, ACT_READ_PROG = 2'h3
   } sie_act_t;

   // Sequencer states, one-hot
   typedef enum logic [4:0] {
      ST_IDLE = 5'h01, ST_ISSUE = 5'h02, ST_WAIT = 5'h04, ST_CAPT = 5'h08, ST_FINISH = 5'h10
   } sie_state_t;

   // Command from the instruction decoder
   typedef struct packed {
      logic valid;
      sie_op_t code;
      logic [7:0] data;
      logic [15:0] ret_pc;
      logic [15:0] target;
   } sie_cmd_t;

   // Memory request toward register file, external data or program memory
   typedef struct packed {
      logic rd;
      logic wr;
      logic ext;
      logic prog;
      logic [15:0] addr;
      logic [7:0] wdata;
   } sie_mem_t;

   // Whole state of the unit
   typedef struct packed {
      sie_state_t st;
      sie_op_t kind;
      logic [2:0] step;
      logic released;
      logic [7:0] port_mode;
      logic [7:0] interrupt_priority;
      logic [7:0] irq;
      logic [7:0] interrupt_mask;
      logic [7:0] flags;
      logic [15:0] sp;
      logic [15:0] tmp;
      logic [2:0] vec;
      sie_mem_t mem;
      logic [7:0] rdata;
      logic reg_hit;
      logic done;
      logic [7:0] pop_data;
      logic pc_load;
      logic [15:0] pc;
      logic int_ack;
      logic [2:0] int_id;
      logic busy;
   } sie_regs_t;

endpackage

// file: verification/sie_mem_model.sv
// Register file, external data and program memory facing the unit
`timescale 1ns/1ps
module sie_mem_model
   import sie_pkg::*;
(
   input wire logic CLK,
   input wire sie_mem_t MEM,
   output logic [7:0] MEM_RDATA
);
   logic [7:0] ram [logic [17:0]];
   logic [17:0] key;
   // Program space ignores the stack location flag
   assign key = MEM.prog ? {2'b10, MEM.addr} : {1'b0, MEM.ext, MEM.addr};
   // Store on write; read data valid one cycle, junk that toggles otherwise
   initial begin
      MEM_RDATA = 8'h00;
      forever begin
         @(posedge CLK);
         if (MEM.wr)
            ram[key] = MEM.wdata;
         if (MEM.rd)
            MEM_RDATA <= ram.exists(key) ? ram[key] : 8'hA5;
         else
            MEM_RDATA <= ~MEM_RDATA;
      end
   end
endmodule // sie_mem_model

// file: verification/sie_stack_int_assertions.sv
// Port checks of the stack and interrupt enable unit
`timescale 1ns/1ps
module sie_stack_int_checker
   import sie_pkg::*;
(
   input wire logic CLK,
   input wire logic RESETN,
   input wire sie_cmd_t CMD,
   input wire logic REG_RD,
   input wire logic [7:0] REG_ADDR,
   input wire logic [7:0] REG_RDATA,
   input wire logic REG_HIT,
   input wire sie_mem_t MEM,
   input wire logic BUSY,
   input wire logic DONE,
   input wire logic PC_LOAD,
   input wire logic [15:0] PC_VALUE,
   input wire logic INT_ACK,
   input wire logic [2:0] INT_ID
);
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RESETN);
   logic take;
   logic mapped;
   // Command taken in idle; mapped register addresses
   assign take = CMD.valid && !BUSY && !DONE;
   assign mapped = REG_ADDR >= 8'hF8 && REG_ADDR != 8'hFD;
   property p_push;
      take && CMD.code == OP_PUSH |-> ##2 (MEM.wr && !MEM.rd) ##2 DONE;
   endproperty
   a_push: assert property (p_push) else $error("push timing");
   property p_call;
      take && CMD.code == OP_CALL |-> ##2 (MEM.wr && MEM.wdata == $past(CMD.ret_pc[7:0], 2))
         ##2 (MEM.wr && MEM.wdata == $past(CMD.ret_pc[15:8], 4)) ##2 (PC_LOAD && PC_VALUE == $past(CMD.target, 6));
   endproperty
   a_call: assert property (p_call) else $error("call bytes");
   property p_pop;
      take && CMD.code == OP_POP |-> ##2 (MEM.rd && !MEM.wr) ##3 (DONE && !PC_LOAD);
   endproperty
   a_pop: assert property (p_pop) else $error("pop timing");
   property p_ret;
      take && CMD.code == OP_RET |-> ##2 MEM.rd ##6 (DONE && PC_LOAD);
   endproperty
   a_ret: assert property (p_ret) else $error("return timing");
   property p_interrupt_return;
      take && CMD.code == OP_INTERRUPT_RETURN |-> ##2 MEM.rd ##9 (DONE && PC_LOAD);
   endproperty
   a_interrupt_return: assert property (p_interrupt_return) else $error("interrupt_return timing");
   property p_ctl;
      take && CMD.code inside {OP_EI, OP_DI} |=> DONE && !BUSY && !MEM.wr && !MEM.rd;
   endproperty
   a_ctl: assert property (p_ctl) else $error("enable op timing");
   property p_hit;
      REG_RD && mapped |=> REG_HIT;
   endproperty
   a_hit: assert property (p_hit) else $error("register hit");
   property p_miss;
      REG_RD && !mapped |=> !REG_HIT && REG_RDATA == 8'h00;
   endproperty
   a_miss: assert property (p_miss) else $error("unmapped read");
   property p_vec;
      MEM.rd && MEM.prog |-> MEM.addr <= 16'h000B && !MEM.wr;
   endproperty
   a_vec: assert property (p_vec) else $error("vector address");
   property p_ack;
      INT_ACK |-> DONE && PC_LOAD && INT_ID <= 3'h5;
   endproperty
   a_ack: assert property (p_ack) else $error("entry end");
   c_push: cover property (take && CMD.code == OP_PUSH);
   c_ack: cover property (INT_ACK);
   c_miss: cover property (REG_RD && !mapped);
endmodule // sie_stack_int_checker
bind sie_stack_int sie_stack_int_checker u_chk (.CLK(CLK), .RESETN(RESETN), .CMD(CMD), .REG_RD(REG_RD),
   .REG_ADDR(REG_ADDR), .REG_RDATA(REG_RDATA), .REG_HIT(REG_HIT), .MEM(MEM), .BUSY(BUSY), .DONE(DONE),
   .PC_LOAD(PC_LOAD), .PC_VALUE(PC_VALUE), .INT_ACK(INT_ACK), .INT_ID(INT_ID));

// file: verification/tb_top.sv
// Self-checking bench of the stack and interrupt enable unit
`timescale 1ns/1ps
module tb_top;
   import sie_pkg::*;
   logic CLK, RESETN, INT_SAMPLE, REG_WE, REG_RD, REG_HIT, BUSY, DONE, PC_LOAD, INT_ACK;
   logic [7:0] REG_ADDR, REG_WDATA, REG_RDATA, MEM_RDATA, POP_DATA, d8, a;
   logic [15:0] INT_PC, PC_VALUE, sp, d16;
   logic [5:0] INT_SOURCE;
   logic [2:0] INT_ID;
   sie_cmd_t CMD;
   sie_mem_t MEM;
   int error_cnt, samples_checked, seed, i, n;
   sie_stack_int u_dut (.CLK(CLK), .RESETN(RESETN), .CMD(CMD), .INT_PC(INT_PC), .INT_SAMPLE(INT_SAMPLE),
      .INT_SOURCE(INT_SOURCE), .REG_WE(REG_WE), .REG_RD(REG_RD), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
      .REG_RDATA(REG_RDATA), .REG_HIT(REG_HIT), .MEM(MEM), .MEM_RDATA(MEM_RDATA), .BUSY(BUSY), .DONE(DONE),
      .POP_DATA(POP_DATA), .PC_LOAD(PC_LOAD), .PC_VALUE(PC_VALUE), .INT_ACK(INT_ACK), .INT_ID(INT_ID));
   sie_mem_model u_mem (.CLK(CLK), .MEM(MEM), .MEM_RDATA(MEM_RDATA));
   // Clock
   initial begin
      CLK = 1'b0;
      forever #20 CLK = ~CLK;
   end
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic reg_wr(input logic [7:0] adr, input logic [7:0] dat);
      @(posedge CLK);
      REG_WE <= 1'b1;
      REG_ADDR <= adr;
      REG_WDATA <= dat;
      @(posedge CLK);
      REG_WE <= 1'b0;
   endtask
   task automatic reg_chk(input logic [7:0] adr, input logic [7:0] exp);
      @(posedge CLK);
      REG_RD <= 1'b1;
      REG_ADDR <= adr;
      @(posedge CLK);
      REG_RD <= 1'b0;
      #1;
      check("read data", REG_RDATA, exp);
      check("read hit", REG_HIT, adr >= 8'hF8 && adr != 8'hFD);
   endtask
   task automatic wait_done();
      // A one-cycle done may already stand just after the accepting edge
      i = 0;
      #1;
      while (DONE !== 1'b1 && i < 40) begin
         @(posedge CLK);
         #1;
         i++;
      end
      if (DONE !== 1'b1) begin
         check("done", DONE, 16'h0001);
         finish_test();
      end
   endtask
   // One command: operand d8, return address d16, target its inverse
   task automatic op(input sie_op_t o);
      @(posedge CLK);
      CMD <= '{1'b1, o, d8, d16, ~d16};
      @(posedge CLK);
      CMD.valid <= 1'b0;
      wait_done();
   endtask
   task automatic pulse(input logic [5:0] s);
      @(posedge CLK);
      INT_SOURCE <= s;
      @(posedge CLK);
      INT_SOURCE <= 6'h00;
   endtask
   task automatic set_sp(input logic [15:0] v);
      reg_wr(8'hFE, v[15:8]);
      reg_wr(8'hFF, v[7:0]);
   endtask
   // Expected serviced source: rotating scan from the priority start
   function automatic logic [2:0] exp_pick(input logic [5:0] pend, input logic [7:0] pri);
      int first;
      first = (pri[2:0] > 3'h5) ? 0 : int'(pri[2:0]);
      for (int k = 0; k < 6; k++) begin
         if (pend[(first + k) % 6]) begin
            return 3'((first + k) % 6);
         end
      end
      return 3'h0;
   endfunction
   // Main sequence
   initial begin
      seed = 91;
      error_cnt = 0;
      samples_checked = 0;
      {RESETN, INT_SAMPLE, REG_WE, REG_RD, REG_ADDR, REG_WDATA, INT_SOURCE, INT_PC, d8, d16} = '0;
      CMD = '0;
      u_mem.ram[18'h20006] = 8'h12;
      u_mem.ram[18'h20007] = 8'h34;
      repeat (12) @(posedge CLK);
      RESETN <= 1'b1;
      // Requests and mask write before the first enable op
      pulse(6'h3F);
      reg_wr(8'hFA, 8'hFF);
      reg_wr(8'hFB, 8'h80);
      pulse(6'h3F);
      for (a = 8'hF8; a != 8'h00; a++)
         reg_chk(a, a == 8'hFB ? 8'h80 : 8'h00);
      reg_chk(8'h10, 8'h00);
      d8 = 8'($random(seed));
      reg_wr(8'hF9, d8);
      reg_chk(8'hF9, d8);
      // External push and pop, first pointer wraps below zero
      for (n = 0; n < 5; n++) begin
         sp = (n == 0) ? 16'h0000 : 16'($random(seed));
         d8 = 8'($random(seed));
         d16 = sp - 16'h0001;
         set_sp(sp);
         op(OP_PUSH);
         check("pushed byte", u_mem.ram[{2'b01, d16}], d8);
         reg_chk(8'hFE, d16[15:8]);
         reg_chk(8'hFF, d16[7:0]);
         op(OP_POP);
         check("popped byte", POP_DATA, d8);
         reg_chk(8'hFF, sp[7:0]);
      end
      // Internal stack: low byte only, high byte untouched
      reg_wr(8'hF8, 8'h04);
      set_sp(16'h5A00);
      d8 = 8'hC3;
      op(OP_PUSH);
      check("internal byte", u_mem.ram[18'h000FF], 8'hC3);
      reg_chk(8'hFE, 8'h5A);
      reg_chk(8'hFF, 8'hFF);
      reg_wr(8'hF8, 8'h00);
      // Call then return
      sp = 16'($random(seed));
      d16 = 16'($random(seed));
      set_sp(sp);
      op(OP_CALL);
      check("call target", PC_VALUE, ~d16);
      check("call low", u_mem.ram[{2'b01, sp - 16'h0001}], d16[7:0]);
      check("call high", u_mem.ram[{2'b01, sp - 16'h0002}], d16[15:8]);
      // Opposite return word preloaded, so only the popped bytes can match
      d16 = ~d16;
      op(OP_RET);
      check("return pc", PC_VALUE, ~d16);
      // Enable, disable, polling, entry and return
      reg_wr(8'hFB, 8'h00);
      op(OP_EI);
      reg_chk(8'hFB, 8'h80);
      op(OP_DI);
      reg_chk(8'hFB, 8'h00);
      reg_wr(8'hFB, 8'h08);
      pulse(6'h09);
      reg_chk(8'hFA, 8'h09);
      d8 = 8'($random(seed));
      reg_wr(8'hFC, d8);
      INT_PC <= 16'($random(seed));
      INT_SAMPLE <= 1'b1;
      reg_wr(8'hFB, 8'h88);
      wait_done();
      check("entry ack", INT_ACK, 16'h0001);
      check("entry id", INT_ID, 16'h0003);
      check("vector", PC_VALUE, 16'h1234);
      INT_SAMPLE <= 1'b0;
      check("saved low", u_mem.ram[{2'b01, sp - 16'h0001}], INT_PC[7:0]);
      check("saved high", u_mem.ram[{2'b01, sp - 16'h0002}], INT_PC[15:8]);
      check("saved flags", u_mem.ram[{2'b01, sp - 16'h0003}], d8);
      reg_chk(8'hFA, 8'h01);
      reg_chk(8'hFB, 8'h08);
      reg_wr(8'hFC, ~d8);
      op(OP_INTERRUPT_RETURN);
      check("interrupt_return pc", PC_VALUE, INT_PC);
      reg_chk(8'hFC, d8);
      reg_chk(8'hFB, 8'h88);
      // Three enabled requests at once, priority start drawn at random
      op(OP_DI);
      reg_wr(8'hFB, 8'h3F);
      pulse(6'h24);
      reg_chk(8'hFA, 8'h25);
      d8 = 8'($random(seed));
      reg_wr(8'hF9, d8);
      INT_SAMPLE <= 1'b1;
      reg_wr(8'hFB, 8'hBF);
      wait_done();
      check("entry pick", INT_ID, exp_pick(6'h25, d8));
      check("pick ack", INT_ACK, 16'h0001);
      INT_SAMPLE <= 1'b0;
      finish_test();
   end
endmodule // tb_top
